//--- dv/spvs_engine_props.sv
/* Concurrent checks on the engine ports.
   Assumes a bind from the bench top file. */
`timescale 1ns/100ps
module spvs_engine_props
  import spvs_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_pkt_valid,
  input wire logic        i_awvalid,
  input wire logic        i_wvalid,
  input wire logic        i_arvalid,
  input wire logic        i_bready,
  input wire logic        i_rready,
  input wire logic        o_awready,
  input wire logic        o_arready,
  input wire logic        o_bvalid,
  input wire logic        o_rvalid,
  input wire logic        o_res_valid,
  input wire logic        o_res_drop,
  input wire logic [1:0]  i_pkt_da_static_queue,
  input wire logic [1:0]  o_bresp,
  input wire logic [1:0]  o_res_queue,
  input wire logic [31:0] o_rdata,
  input wire logic [2:0]  o_res_tx_ports,
  input wire logic [2:0]  o_port_learn_en,
  input wire logic [2:0]  o_port_forward,
  input spvs_prio_src_t   o_res_prio_src
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_res; i_pkt_valid |=> o_res_valid; endproperty
  a_res: assert property (p_res) else $error("no result pulse");
  property p_nores; !i_pkt_valid |=> !o_res_valid; endproperty
  a_nores: assert property (p_nores) else $error("spurious result");
  property p_src; o_res_valid |-> $onehot(o_res_prio_src); endproperty
  a_src: assert property (p_src) else $error("source not one-hot");
  property p_stat; o_res_valid && o_res_prio_src == SPVS_SRC_STATIC
    |-> o_res_queue == $past(i_pkt_da_static_queue); endproperty
  a_stat: assert property (p_stat) else $error("static queue wrong");
  property p_drop; o_res_valid && o_res_drop |-> o_res_tx_ports == 3'h0; endproperty
  a_drop: assert property (p_drop) else $error("dropped yet sent");
  property p_learn; &(~o_port_forward | o_port_learn_en); endproperty
  a_learn: assert property (p_learn) else $error("forwarding without learning");
  property p_aw; i_awvalid && i_wvalid && !o_bvalid && !o_awready |-> ##[1:2] o_awready;
  endproperty
  a_aw: assert property (p_aw) else $error("write not taken");
  property p_b; o_awready |=> o_bvalid; endproperty
  a_b: assert property (p_b) else $error("no write response");
  property p_r; o_arready |=> o_rvalid; endproperty
  a_r: assert property (p_r) else $error("no read response");
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("response not held");
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  c_drop: cover property (o_res_valid && o_res_drop);
  c_stat: cover property (o_res_valid && o_res_prio_src == SPVS_SRC_STATIC);
  c_blk: cover property (o_port_forward != 3'h7);
endmodule : spvs_engine_props

//--- dv/tb_spvs_engine.sv
/* Self-checking bench of the engine.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/100ps
module tb_spvs_engine;
  import spvs_pkg::*;
  logic i_sys_clk = 0, i_rst = 1, i_awvalid = 0, i_wvalid = 0, i_arvalid = 0, i_bready = 0;
  logic i_rready = 0, i_pkt_valid = 0, i_pkt_tagged = 0, i_pkt_is_ipv4 = 0, i_pkt_is_ipv6 = 0;
  logic i_pkt_da_known = 0, i_pkt_da_static = 0, i_pkt_da_override = 0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, i_pkt_tos = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rd_v;
  logic [3:0] i_wstrb = 4'hF;
  logic [1:0] i_pkt_src_port = 2'h0, i_pkt_da_static_queue = 2'h1, o_bresp, o_rresp, o_res_queue, rd_r, wr_r;
  logic [2:0] i_pkt_dst_ports = 3'h7, i_pkt_tag_prio = 3'h0, o_res_member, o_res_untag;
  logic [2:0] o_res_tx_ports, o_port_learn_en, o_port_forward;
  logic [11:0] i_pkt_tag_vid = 12'h000, o_res_vid;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_res_valid, o_res_drop, o_res_learn;
  spvs_prio_src_t o_res_prio_src;
  int n_mismatch = 0, check_count = 0;
  spvs_engine i_spvs_engine (.i_sys_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pkt_valid, .i_pkt_src_port,
    .i_pkt_dst_ports, .i_pkt_tagged, .i_pkt_tag_vid, .i_pkt_tag_prio, .i_pkt_is_ipv4,
    .i_pkt_is_ipv6, .i_pkt_tos, .i_pkt_da_known, .i_pkt_da_static, .i_pkt_da_override,
    .i_pkt_da_static_queue, .o_res_valid, .o_res_drop, .o_res_queue, .o_res_prio_src,
    .o_res_vid, .o_res_member, .o_res_untag, .o_res_tx_ports, .o_res_learn,
    .o_port_learn_en, .o_port_forward);
  always #2.5 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_awaddr <= a; i_wdata <= d; i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    do @(posedge i_sys_clk); while (o_awready !== 1'b1);
    i_awvalid <= 0; i_wvalid <= 0;
    do @(posedge i_sys_clk); while (o_bvalid !== 1'b1);
    wr_r = o_bresp;
    i_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1;
    do @(posedge i_sys_clk); while (o_arready !== 1'b1);
    i_arvalid <= 0;
    do @(posedge i_sys_clk); while (o_rvalid !== 1'b1);
    rd_v = o_rdata; rd_r = o_rresp; i_rready <= 0;
  endtask : rd
  // Flags are {override, static, known, ipv6, ipv4}; result is {drop, queue, source}.
  task automatic pk(input logic [1:0] s, input logic [11:0] v, input logic [2:0] p,
                    input logic [7:0] tos, input logic [4:0] f, input logic [7:0] e);
    i_pkt_src_port <= s; i_pkt_tagged <= (v != 12'h000); i_pkt_tag_vid <= v; i_pkt_tag_prio <= p;
    i_pkt_tos <= tos; {i_pkt_da_override, i_pkt_da_static, i_pkt_da_known, i_pkt_is_ipv6,
    i_pkt_is_ipv4} <= f; i_pkt_valid <= 1;
    @(posedge i_sys_clk);
    i_pkt_valid <= 0;
    #1 chk({o_res_drop, o_res_queue, o_res_prio_src}, e);
    @(posedge i_sys_clk);
  endtask : pk
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h00); chk(rd_v, 32'h0);
    rd(8'h08); chk(rd_v, 32'hFA50);
    rd(8'h0C); chk(rd_v, 32'hFAC688);
    rd(8'h40); chk(rd_r, 32'h2);
    wr(8'h40, 32'h0); chk(wr_r, 32'h2);
    wr(8'h20, 32'h0); chk(wr_r, 32'h0);
  endtask : t_regs
  task automatic t_stp;
    wr(8'h04, 32'h24); repeat (2) @(posedge i_sys_clk);
    chk({o_port_learn_en, o_port_forward}, 6'h29);
    wr(8'h04, 32'h3C); repeat (2) @(posedge i_sys_clk);
    chk({o_port_learn_en, o_port_forward}, 6'h09);
    pk(2'h1, 12'h0, 3'h0, 8'h0, 5'h04, 8'h81); chk(o_res_learn, 32'h0);
    pk(2'h1, 12'h0, 3'h0, 8'h0, 5'h1C, 8'h01); chk(o_res_tx_ports, 32'h5);
    wr(8'h04, 32'h0);
  endtask : t_stp
  task automatic t_prio;
    wr(8'h1C, 32'h5001); wr(8'h18, 32'h40); rd(8'h24); chk(rd_v, 32'h0);
    pk(2'h0, 12'h0, 3'h0, 8'h0, 5'h04, 8'h41); chk(o_res_vid, 32'h1);
    wr(8'h00, 32'h08); pk(2'h0, 12'h0, 3'h0, 8'hE0, 5'h05, 8'h62);
    wr(8'h00, 32'h0C); pk(2'h0, 12'h0, 3'h0, 8'h0, 5'h0D, 8'h30);
    for (int i = 0; i < 64; i++) begin
      wr(8'h2C, i ^ 32'h2A); wr(8'h28, i);
    end
    wr(8'h28, 32'hAE); rd(8'h30); chk(rd_v, 32'h4);
    wr(8'h00, 32'h10);
    pk(2'h0, 12'h0, 3'h0, 8'hB8, 5'h06, 8'h44);
  endtask : t_prio
  task automatic t_vlan;
    wr(8'h1C, 32'h1B123); wr(8'h18, 32'h0); wr(8'h00, 32'h221);
    pk(2'h0, 12'h123, 3'h3, 8'h0, 5'h04, 8'h28); chk(o_res_member, 32'h3);
    chk(o_res_untag, 32'h2); chk(o_res_tx_ports, 32'h2); chk(o_res_learn, 32'h1);
    pk(2'h0, 12'hFFF, 3'h3, 8'h0, 5'h04, 8'hA8);
    pk(2'h0, 12'h456, 3'h3, 8'h0, 5'h00, 8'hA8); chk(o_res_member, 32'h0);
  endtask : t_vlan
  task automatic summarize;
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 0;
    @(posedge i_sys_clk);
    t_regs(); t_stp(); t_prio(); t_vlan();
    summarize();
  end
  initial begin
    #20000 n_mismatch++;
    summarize();
  end
endmodule : tb_spvs_engine
bind spvs_engine spvs_engine_props i_spvs_engine_props (.i_sys_clk, .i_rst, .i_pkt_valid,
  .i_awvalid, .i_wvalid, .i_arvalid, .i_bready, .i_rready, .o_awready, .o_arready, .o_bvalid,
  .o_rvalid, .o_res_valid, .o_res_drop, .i_pkt_da_static_queue, .o_bresp, .o_res_queue, .o_rdata,
  .o_res_tx_ports, .o_port_learn_en, .o_port_forward, .o_res_prio_src);

//--- hdl/spvs_cfg.svh
/*
  Register offsets, field positions, reset values and sizes of the switch
  priority, VLAN and spanning tree block.
  Assumes inclusion by bare name from the block's design files.
*/
`ifndef SPVS_CFG_SVH
`define SPVS_CFG_SVH

`define SPVS_ADDR_W          8
`define SPVS_OFF_GCFG        8'h00
`define SPVS_OFF_PSTATE      8'h04
`define SPVS_OFF_TCLASS      8'h08
`define SPVS_OFF_REGEN0      8'h0C
`define SPVS_OFF_REGEN1      8'h10
`define SPVS_OFF_REGEN2      8'h14
`define SPVS_OFF_VCMD        8'h18
`define SPVS_OFF_VWDATA      8'h1C
`define SPVS_OFF_VRDATA      8'h20
`define SPVS_OFF_VSTAT       8'h24
`define SPVS_OFF_DSCMD       8'h28
`define SPVS_OFF_DSWDATA     8'h2C
`define SPVS_OFF_DSRDATA     8'h30
`define SPVS_OFF_DSSTAT      8'h34

`define SPVS_GCFG_VLAN_EN    0
`define SPVS_GCFG_MEMB_CHK   1
`define SPVS_GCFG_DA_PRIO    2
`define SPVS_GCFG_PREC_EN    3
`define SPVS_GCFG_DS_EN      4
`define SPVS_GCFG_VPRIO_EN   5
`define SPVS_GCFG_HYB_LSB    8

`define SPVS_VCMD_RNW        5
`define SPVS_VCMD_PORT_DEFAULT_VLAN_ID_SEL   6
`define SPVS_DSCMD_RNW       7

`define SPVS_VE_VID_MSB      11
`define SPVS_VE_MEM_LSB      12
`define SPVS_VE_UNT_LSB      15
`define SPVS_VE_W            18
`define SPVS_PORT_DEFAULT_VLAN_ID_PRIO_LSB   12
`define SPVS_PORT_DEFAULT_VLAN_ID_W          15

`define SPVS_RST_GCFG        11'h000
`define SPVS_RST_PSTATE      6'h00
`define SPVS_RST_TCLASS      16'hFA50
`define SPVS_RST_REGEN       24'hFAC688
`define SPVS_RST_PORT_DEFAULT_VLAN_ID        15'h0001
`define SPVS_VID_NULL        12'h000
`define SPVS_VID_RSVD        12'hFFF
`define SPVS_RESP_OKAY       2'h0
`define SPVS_RESP_SLVERR     2'h2

`endif

//--- hdl/spvs_engine.sv
/*
  Switch engine slice: transmit queue selection, VLAN resolution and
  spanning tree port state, configured over AXI4-Lite.
  Assumes packet descriptors synchronous to i_sys_clk, one per valid cycle.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "spvs_cfg.svh"

module spvs_engine
  import spvs_pkg::*;
#(
  parameter int VLAN_ENTRIES = 16,
  parameter int DS_ENTRIES   = 64
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic [`SPVS_ADDR_W-1:0]   i_awaddr,
  input  wire logic                      i_awvalid,
  output logic                           o_awready,
  input  wire logic [31:0]               i_wdata,
  input  wire logic [3:0]                i_wstrb,
  input  wire logic                      i_wvalid,
  output logic                           o_wready,
  output logic      [1:0]                o_bresp,
  output logic                           o_bvalid,
  input  wire logic                      i_bready,
  input  wire logic [`SPVS_ADDR_W-1:0]   i_araddr,
  input  wire logic                      i_arvalid,
  output logic                           o_arready,
  output logic      [31:0]               o_rdata,
  output logic      [1:0]                o_rresp,
  output logic                           o_rvalid,
  input  wire logic                      i_rready,
  input  wire logic                      i_pkt_valid,
  input  wire logic [1:0]                i_pkt_src_port,
  input  wire logic [2:0]                i_pkt_dst_ports,
  input  wire logic                      i_pkt_tagged,
  input  wire logic [11:0]               i_pkt_tag_vid,
  input  wire logic [2:0]                i_pkt_tag_prio,
  input  wire logic                      i_pkt_is_ipv4,
  input  wire logic                      i_pkt_is_ipv6,
  input  wire logic [7:0]                i_pkt_tos,
  input  wire logic                      i_pkt_da_known,
  input  wire logic                      i_pkt_da_static,
  input  wire logic                      i_pkt_da_override,
  input  wire logic [1:0]                i_pkt_da_static_queue,
  output logic                           o_res_valid,
  output logic                           o_res_drop,
  output logic      [1:0]                o_res_queue,
  output spvs_prio_src_t                 o_res_prio_src,
  output logic      [11:0]               o_res_vid,
  output logic      [2:0]                o_res_member,
  output logic      [2:0]                o_res_untag,
  output logic      [2:0]                o_res_tx_ports,
  output logic                           o_res_learn,
  output logic      [2:0]                o_port_learn_en,
  output logic      [2:0]                o_port_forward
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic [10:0]                                  gcfg;
  logic [5:0]                                   port_tree_state_reg;
  logic [15:0]                                  tclass;
  logic [2:0][23:0]                             regen;
  logic [VLAN_ENTRIES-1:0][`SPVS_VE_W-1:0]      vlan_tbl;
  logic [2:0][`SPVS_PORT_DEFAULT_VLAN_ID_W-1:0]                 port_default_vlan_id_tbl;
  logic [2:0]                                   ds_tbl [DS_ENTRIES];
  logic [6:0]                                   vlan_table_command_reg;
  logic [17:0]                                  vlan_wdata;
  logic [17:0]                                  vlan_rdata;
  logic                                         vlan_busy;
  logic [7:0]                                   ds_table_command_reg;
  logic [2:0]                                   ds_wdata;
  logic [2:0]                                   ds_rdata;
  logic                                         ds_busy;
  logic [`SPVS_ADDR_W-1:0]                      rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite decode.

  wire        wr_go     = i_awvalid & i_wvalid & ~o_awready & ~o_bvalid;
  wire        wr_fire   = i_awvalid & o_awready & i_wvalid & o_wready;
  wire        rd_go     = i_arvalid & ~o_arready & ~o_rvalid;
  wire        rd_fire   = i_arvalid & o_arready;
  wire [31:0] wmask     = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
  wire        wa_gcfg   = i_awaddr == `SPVS_OFF_GCFG;
  wire        wa_pstate = i_awaddr == `SPVS_OFF_PSTATE;
  wire        wa_tclass = i_awaddr == `SPVS_OFF_TCLASS;
  wire        wa_reg0   = i_awaddr == `SPVS_OFF_REGEN0;
  wire        wa_reg1   = i_awaddr == `SPVS_OFF_REGEN1;
  wire        wa_reg2   = i_awaddr == `SPVS_OFF_REGEN2;
  wire        wa_vcmd   = i_awaddr == `SPVS_OFF_VCMD;
  wire        wa_vwdata = i_awaddr == `SPVS_OFF_VWDATA;
  wire        wa_dscmd  = i_awaddr == `SPVS_OFF_DSCMD;
  wire        wa_dswdat = i_awaddr == `SPVS_OFF_DSWDATA;
  wire        wa_ro     = (i_awaddr == `SPVS_OFF_VRDATA) | (i_awaddr == `SPVS_OFF_VSTAT) |
                          (i_awaddr == `SPVS_OFF_DSRDATA) | (i_awaddr == `SPVS_OFF_DSSTAT);
  wire        wa_ok     = wa_gcfg | wa_pstate | wa_tclass | wa_reg0 | wa_reg1 | wa_reg2 |
                          wa_vcmd | wa_vwdata | wa_dscmd | wa_dswdat | wa_ro;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  wire [31:0] next_gcfg   = merge({21'h0, gcfg}, i_wdata, wmask);
  wire [31:0] next_pstate = merge({26'h0, port_tree_state_reg}, i_wdata, wmask);
  wire [31:0] next_tclass = merge({16'h0, tclass}, i_wdata, wmask);
  wire [31:0] next_vcmd   = merge({25'h0, vlan_table_command_reg}, i_wdata, wmask);
  wire [31:0] next_vwdata = merge({14'h0, vlan_wdata}, i_wdata, wmask);
  wire [31:0] next_dscmd  = merge({24'h0, ds_table_command_reg}, i_wdata, wmask);
  wire [31:0] next_dswdat = merge({29'h0, ds_wdata}, i_wdata, wmask);
  wire [2:0][31:0] next_regen;
  for (genvar p = 0; p < 3; p++) begin : g_regen_merge
    assign next_regen[p] = merge({8'h0, regen[p]}, i_wdata, wmask);
  end

  wire [31:0] rd_mux =
    (rd_addr == `SPVS_OFF_GCFG)    ? {21'h0, gcfg} :
    (rd_addr == `SPVS_OFF_PSTATE)  ? {26'h0, port_tree_state_reg} :
    (rd_addr == `SPVS_OFF_TCLASS)  ? {16'h0, tclass} :
    (rd_addr == `SPVS_OFF_REGEN0)  ? {8'h0, regen[0]} :
    (rd_addr == `SPVS_OFF_REGEN1)  ? {8'h0, regen[1]} :
    (rd_addr == `SPVS_OFF_REGEN2)  ? {8'h0, regen[2]} :
    (rd_addr == `SPVS_OFF_VCMD)    ? {25'h0, vlan_table_command_reg} :
    (rd_addr == `SPVS_OFF_VWDATA)  ? {14'h0, vlan_wdata} :
    (rd_addr == `SPVS_OFF_VRDATA)  ? {14'h0, vlan_rdata} :
    (rd_addr == `SPVS_OFF_VSTAT)   ? {31'h0, vlan_busy} :
    (rd_addr == `SPVS_OFF_DSCMD)   ? {24'h0, ds_table_command_reg} :
    (rd_addr == `SPVS_OFF_DSWDATA) ? {29'h0, ds_wdata} :
    (rd_addr == `SPVS_OFF_DSRDATA) ? {29'h0, ds_rdata} :
    (rd_addr == `SPVS_OFF_DSSTAT)  ? {31'h0, ds_busy} : 32'h0;
  wire rd_ok = (rd_addr <= `SPVS_OFF_DSSTAT) & (rd_addr[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake.

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `SPVS_RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rresp   <= `SPVS_RESP_OKAY;
      o_rdata   <= 32'h0;
      rd_addr   <= 8'h0;
    end else begin
      o_awready <= wr_go;
      o_wready  <= wr_go;
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wa_ok ? `SPVS_RESP_OKAY : `SPVS_RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
      o_arready <= rd_go;
      if (rd_go) begin
        rd_addr <= i_araddr;
      end
      if (rd_fire) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_mux;
        o_rresp  <= rd_ok ? `SPVS_RESP_OKAY : `SPVS_RESP_SLVERR;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers and indirect table access.

  wire       vcmd_go  = wr_fire & wa_vcmd;
  wire [4:0] v_idx    = next_vcmd[4:0];
  wire       v_port_default_vlan_id   = next_vcmd[`SPVS_VCMD_PORT_DEFAULT_VLAN_ID_SEL];
  wire       v_rnw    = next_vcmd[`SPVS_VCMD_RNW];
  wire       dscmd_go = wr_fire & wa_dscmd;
  wire [5:0] ds_idx   = next_dscmd[5:0];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      gcfg                   <= `SPVS_RST_GCFG;
      port_tree_state_reg    <= `SPVS_RST_PSTATE;
      tclass                 <= `SPVS_RST_TCLASS;
      regen                  <= {3{`SPVS_RST_REGEN}};
      vlan_tbl               <= '0;
      port_default_vlan_id_tbl               <= {3{`SPVS_RST_PORT_DEFAULT_VLAN_ID}};
      vlan_table_command_reg <= 7'h00;
      vlan_wdata             <= 18'h00000;
      vlan_rdata             <= 18'h00000;
      vlan_busy              <= 1'b0;
      ds_table_command_reg   <= 8'h00;
      ds_wdata               <= 3'h0;
      ds_rdata               <= 3'h0;
      ds_busy                <= 1'b0;
    end else begin
      vlan_busy <= vcmd_go;
      ds_busy   <= dscmd_go;
      if (wr_fire & wa_gcfg)   gcfg <= next_gcfg[10:0];
      if (wr_fire & wa_pstate) port_tree_state_reg <= next_pstate[5:0];
      if (wr_fire & wa_tclass) tclass <= next_tclass[15:0];
      if (wr_fire & wa_reg0)   regen[0] <= next_regen[0][23:0];
      if (wr_fire & wa_reg1)   regen[1] <= next_regen[1][23:0];
      if (wr_fire & wa_reg2)   regen[2] <= next_regen[2][23:0];
      if (wr_fire & wa_vwdata) vlan_wdata <= next_vwdata[17:0];
      if (wr_fire & wa_dswdat) ds_wdata <= next_dswdat[2:0];
      if (vcmd_go) begin
        vlan_table_command_reg <= next_vcmd[6:0];
        if (v_port_default_vlan_id && v_idx < 5'd3) begin
          if (v_rnw) vlan_rdata <= {3'h0, port_default_vlan_id_tbl[v_idx[1:0]]};
          else       port_default_vlan_id_tbl[v_idx[1:0]] <= vlan_wdata[`SPVS_PORT_DEFAULT_VLAN_ID_W-1:0];
        end else if (!v_port_default_vlan_id && v_idx < 5'(VLAN_ENTRIES)) begin
          if (v_rnw) vlan_rdata <= vlan_tbl[v_idx[3:0]];
          else       vlan_tbl[v_idx[3:0]] <= vlan_wdata;
        end
      end
      if (dscmd_go) begin
        ds_table_command_reg <= next_dscmd[7:0];
        if (next_dscmd[`SPVS_DSCMD_RNW]) ds_rdata <= ds_tbl[ds_idx];
      end
    end
  end

  // The diffserv table has no reset; software must fill it before use.
  always_ff @(posedge i_sys_clk) begin
    if (dscmd_go && !next_dscmd[`SPVS_DSCMD_RNW]) begin
      ds_tbl[ds_idx] <= ds_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spanning tree port state.

  logic [2:0] port_fwd;
  logic [2:0] port_learn;
  for (genvar p = 0; p < 3; p++) begin : g_tree
    wire spvs_tree_state_t st = spvs_tree_state_t'(port_tree_state_reg[2*p+:2]);
    assign port_fwd[p]   = st == SPVS_ST_FORWARD;
    assign port_learn[p] = (st == SPVS_ST_FORWARD) | (st == SPVS_ST_LEARN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // VLAN resolution.

  wire        src_ok    = i_pkt_src_port != 2'h3;
  wire [1:0]  src       = src_ok ? i_pkt_src_port : 2'h0;
  wire [2:0]  src_bit   = 3'h1 << src;
  wire [`SPVS_PORT_DEFAULT_VLAN_ID_W-1:0] port_default_vlan_id_ent = port_default_vlan_id_tbl[src];
  wire        vid_tag   = i_pkt_tagged & (i_pkt_tag_vid != `SPVS_VID_NULL);
  wire        vid_rsvd  = vid_tag & (i_pkt_tag_vid == `SPVS_VID_RSVD);
  wire [11:0] res_vid   = vid_tag ? i_pkt_tag_vid : port_default_vlan_id_ent[11:0];
  wire        vlan_en   = gcfg[`SPVS_GCFG_VLAN_EN];
  wire        lk_hit;
  wire [2:0]  lk_member;
  wire [2:0]  lk_untag;

  spvs_vlan_lookup #(
    .ENTRIES  (VLAN_ENTRIES)
  ) u_lookup (
    .i_table  (vlan_tbl),
    .i_vid    (res_vid),
    .o_hit    (lk_hit),
    .o_member (lk_member),
    .o_untag  (lk_untag)
  );

  wire        use_entry = lk_hit & ~vid_rsvd;
  wire [2:0]  member    = use_entry ? lk_member : 3'h0;
  wire [2:0]  untag     = (use_entry ? lk_untag : 3'h0) & gcfg[`SPVS_GCFG_HYB_LSB+:3];
  wire        override  = i_pkt_da_static & i_pkt_da_override;
  wire [2:0]  fwd_mask  = override ? 3'h7 : port_fwd;
  wire [2:0]  vmask     = vlan_en ? member : 3'h7;
  wire [2:0]  tx_ports  = i_pkt_dst_ports & fwd_mask & vmask & ~src_bit;
  wire        memb_chk  = vlan_en & gcfg[`SPVS_GCFG_MEMB_CHK];
  wire        drop      = ~src_ok |
                          (~override & ~port_fwd[src]) |
                          (vlan_en & vid_rsvd) |
                          (memb_chk & ~member[src]) |
                          (memb_chk & ((i_pkt_dst_ports & ~member) != 3'h0)) |
                          (vlan_en & ~i_pkt_da_known & (tx_ports == 3'h0));

  ////////////////////////////////////////////////////////////////////////////
  // Transmit priority selection.

  wire        is_ip     = i_pkt_is_ipv4 | i_pkt_is_ipv6;
  wire [2:0]  prec_prio = i_pkt_tos[7:5];
  wire [2:0]  ds_prio   = ds_tbl[i_pkt_tos[7:2]];
  wire [23:0] src_regen = regen[src];
  wire [2:0]  vlan_prio = src_regen[3*i_pkt_tag_prio+:3];
  wire [2:0]  dflt_prio = port_default_vlan_id_ent[`SPVS_PORT_DEFAULT_VLAN_ID_PRIO_LSB+:3];
  wire        sel_stat  = gcfg[`SPVS_GCFG_DA_PRIO] & i_pkt_da_static;
  wire        sel_vlan  = gcfg[`SPVS_GCFG_VPRIO_EN] & i_pkt_tagged;
  wire        sel_ds    = gcfg[`SPVS_GCFG_DS_EN] & is_ip;
  wire        sel_prec  = gcfg[`SPVS_GCFG_PREC_EN] & i_pkt_is_ipv4;
  wire spvs_prio_src_t next_src =
    sel_stat ? SPVS_SRC_STATIC :
    sel_vlan ? SPVS_SRC_VLAN :
    sel_ds   ? SPVS_SRC_DS :
    sel_prec ? SPVS_SRC_PREC : SPVS_SRC_DEFAULT;
  wire [2:0]  sel_prio  = sel_vlan ? vlan_prio :
                          sel_ds   ? ds_prio :
                          sel_prec ? prec_prio : dflt_prio;
  wire [1:0]  next_queue = sel_stat ? i_pkt_da_static_queue :
                                      tclass[2*sel_prio+:2];

  ////////////////////////////////////////////////////////////////////////////
  // Result register.

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_res_valid     <= 1'b0;
      o_res_drop      <= 1'b0;
      o_res_queue     <= 2'h0;
      o_res_prio_src  <= SPVS_SRC_DEFAULT;
      o_res_vid       <= 12'h000;
      o_res_member    <= 3'h0;
      o_res_untag     <= 3'h0;
      o_res_tx_ports  <= 3'h0;
      o_res_learn     <= 1'b0;
      o_port_learn_en <= 3'h0;
      o_port_forward  <= 3'h0;
    end else begin
      o_res_valid     <= i_pkt_valid;
      o_port_learn_en <= port_learn;
      o_port_forward  <= port_fwd;
      if (i_pkt_valid) begin
        o_res_drop     <= drop;
        o_res_queue    <= next_queue;
        o_res_prio_src <= next_src;
        o_res_vid      <= res_vid;
        o_res_member   <= member;
        o_res_untag    <= untag;
        o_res_tx_ports <= drop ? 3'h0 : tx_ports;
        o_res_learn    <= src_ok & port_learn[src];
      end
    end
  end

endmodule : spvs_engine

//--- hdl/spvs_pkg.sv
/*
  Types of the switch priority, VLAN and spanning tree block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spvs_pkg;

  typedef enum logic [1:0] {
    SPVS_ST_FORWARD = 2'h0,
    SPVS_ST_BLOCK   = 2'h1,
    SPVS_ST_LEARN   = 2'h2,
    SPVS_ST_LISTEN  = 2'h3
  } spvs_tree_state_t;

  typedef enum logic [4:0] {
    SPVS_SRC_DEFAULT = 5'h01,
    SPVS_SRC_PREC    = 5'h02,
    SPVS_SRC_DS      = 5'h04,
    SPVS_SRC_VLAN    = 5'h08,
    SPVS_SRC_STATIC  = 5'h10
  } spvs_prio_src_t;

endpackage : spvs_pkg

//--- hdl/spvs_vlan_lookup.sv
/*
  Associative search of the active VLAN table for one identifier.
  Assumes the table arrives flattened as packed entries from the owner.
*/
`timescale 1ns/100ps
`include "spvs_cfg.svh"

module spvs_vlan_lookup
  import spvs_pkg::*;
#(
  parameter int ENTRIES = 16
) (
  input  wire logic [ENTRIES-1:0][`SPVS_VE_W-1:0] i_table,
  input  wire logic [11:0]                         i_vid,
  output logic                                     o_hit,
  output logic      [2:0]                          o_member,
  output logic      [2:0]                          o_untag
);

  // First matching entry wins; a miss yields an empty membership.
  always_comb begin
    o_hit    = 1'b0;
    o_member = 3'h0;
    o_untag  = 3'h0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (i_table[i][`SPVS_VE_VID_MSB:0] == i_vid) begin
        o_hit    = 1'b1;
        o_member = i_table[i][`SPVS_VE_MEM_LSB+:3];
        o_untag  = i_table[i][`SPVS_VE_UNT_LSB+:3];
      end
    end
  end

endmodule : spvs_vlan_lookup
